/* File: hdl/field_status_security_logic.sv */
`timescale 1ns/1ns
// Notes on behaviour
// R01 - additional status reply is eight bytes
// R02 - undefined additional status bits read zero
// R03 - error flags raise summary bits 4, 7
// R04 - warnings raise bit 4; full-scale also 0
// R05 - link failure sets byte 4 bit 0
// R06 - configuration mismatch sets byte 4 bit 1
// R07 - expired-login write refused, raises mismatch
// R08 - reads are always accepted
// R09 - secured writes need sufficient remote level
// R10 - no remote writes during local menu use
// R11 - login ends five minutes after last write
// R12 - invalid pin ends login at once
// R13 - security word, bit 0 means secured
// R14 - bits 1..5 one-hot local menu level
// R15 - bits 8..12 one-hot remote level
// R16 - fixed mode holds loop at 4 mA
// R17 - summary bit 3 set while output fixed
// R18 - fixed mode iff poll address non-zero
// R19 - poll address writes need no login
// R20 - alarm setting ignored in multi-drop
// R21 - actions 6 and 28 need no login
// R22 - clear actions need service when secured
// R23 - action 23 resets, needs service level when secured
// R24 - bit 4 more status, bit 7 malfunction
// R25 - summary bits are OR of their flags
module field_status_security_logic
  import field_status_pkg::*;
#(
  parameter longint LOGIN_LIMIT = LOGIN_CYCLES
) (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        resetn_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // meter side
  output logic      [15:0] loop_current_o,
  output logic             param_write_o,
  output logic      [7:0]  action_pulse_o,
  output logic             remote_reset_o
);

  // ---------------------------------------------------------------
  // software-facing state
  // ---------------------------------------------------------------
  meter_flags_s          flags_q;
  logic [8:0]            ctl_q;
  logic [7:0]            poll_q;
  access_level_e         remote_q;
  logic                  mismatch_q;
  logic [15:0]           setpoint_q;
  logic [63:0]           add_status;
  logic [7:0]            summary;
  logic [15:0]           sec_word;
  logic [31:0]           result_q;
  // 33 bits: five minutes of 25 MHz cycles overflows 32
  logic [32:0]           login_cnt_q;
  logic                  fixed_mode;
  logic                  secured;

  logic wr_en;
  logic acc;
  assign acc   = psel_i & penable_i;
  assign wr_en = acc & pwrite_i;

  assign secured    = ctl_q[CTL_SECURED];
  // R18 fixed mode decode
  assign fixed_mode = (poll_q != POLL_RESET);

  function automatic logic [4:0] one_hot(input logic [2:0] lvl);
    one_hot = 5'h01 << lvl;
  endfunction : one_hot

  function automatic logic level_ok(input logic [2:0] have,
                                    input logic [2:0] need);
    level_ok = (have >= need);
  endfunction : level_ok

  // ---------------------------------------------------------------
  // additional status image
  // ---------------------------------------------------------------
  always_comb begin
    add_status = 64'h0;
    // R02 only defined bits are mapped
    add_status[7:0] = flags_q.byte0;
    add_status[8]   = flags_q.byte1[0];
    // R05 internal link failure
    add_status[32]  = ctl_q[CTL_LINK_FAIL];
    // R06 configuration mismatch
    add_status[33]  = mismatch_q;
  end

  // ---------------------------------------------------------------
  // summary device status
  // ---------------------------------------------------------------
  always_comb begin
    summary = 8'h00;
    // R25 each bit is an OR of its contributors
    // R03 error-class flags
    summary[SUM_MALFUNCTION] = add_status[0] | add_status[1] |
                               add_status[3] | add_status[7] |
                               add_status[8] | add_status[32];
    // R04 warning flags
    // R24 more status is any defined flag
    summary[SUM_MORE_STATUS] = (|add_status[7:0]) | add_status[8] |
                               add_status[32] | add_status[33];
    summary[SUM_PV_RANGE]    = add_status[2];
    // R17 output fixed flag
    summary[SUM_FIXED]       = fixed_mode;
  end

  // ---------------------------------------------------------------
  // security word
  // ---------------------------------------------------------------
  always_comb begin
    sec_word = 16'h0000;
    // R13 secured flag, undefined bits zero
    sec_word[SEC_SECURED] = secured;
    // R14 local menu level one-hot
    sec_word[SEC_LOCAL_BASE +: 5]  = one_hot(ctl_q[CTL_LEVEL_LSB +: 3]);
    // R15 remote level one-hot
    sec_word[SEC_REMOTE_BASE +: 5] = one_hot(remote_q);
  end

  // ---------------------------------------------------------------
  // write request decisions
  // ---------------------------------------------------------------
  // param write: pwdata[2:0] required level
  logic       param_req;
  logic       param_ok;
  logic       act_req;
  logic [7:0] act_code;
  logic       act_ok;
  logic       act_service;
  logic       login_req;

  assign param_req = wr_en & (paddr_i == ADDR_WRITE_REQ);
  assign act_req   = wr_en & (paddr_i == ADDR_ACTION);
  assign login_req = wr_en & (paddr_i == ADDR_LOGIN);
  assign act_code  = pwdata_i[7:0];

  // R09 secured writes need level
  // R10 local menu blocks all parameter writes
  assign param_ok = ~ctl_q[CTL_LOCAL_MENU] &
                    (~secured | level_ok(remote_q, pwdata_i[2:0]));

  // R22 clear and reset-count codes
  // R23 remote reset code
  assign act_service = ((act_code >= ACT_CLEAR_FIRST) &&
                        (act_code <= ACT_CLEAR_LAST)) ||
                       (act_code == ACT_CLEAR_PWR) ||
                       (act_code == ACT_BATCH) ||
                       (act_code == ACT_RESET);
  // R21 save and logoff need no login
  assign act_ok = ~ctl_q[CTL_LOCAL_MENU] &
                  ((act_code == ACT_SAVE_TOTALS) ||
                   (act_code == ACT_LOGOFF) ||
                   (act_service &
                    (~secured | level_ok(remote_q, LVL_SERVICE))));

  // ---------------------------------------------------------------
  // control and meter flags
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctl_q      <= 9'h000;
      flags_q    <= '0;
    end else if (wr_en && paddr_i == ADDR_CONTROL) begin
      ctl_q <= pwdata_i[8:0];
    end else if (wr_en && paddr_i == ADDR_METER_FLAGS) begin
      flags_q <= pwdata_i[15:0];
    end
  end

  // R19 poll address written with no login check
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      poll_q <= POLL_RESET;
    end else if (wr_en && paddr_i == ADDR_POLL) begin
      poll_q <= pwdata_i[7:0];
    end
  end

  // ---------------------------------------------------------------
  // remote login and timeout
  // ---------------------------------------------------------------
  logic login_expire;
  assign login_expire = (login_cnt_q == 33'h0) & (remote_q != LVL_NONE);

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      remote_q    <= LVL_NONE;
      login_cnt_q <= 33'h0;
    end else if (login_req) begin
      // login: pwdata[31] pin valid, [2:0] granted level
      if (pwdata_i[31]) begin
        remote_q    <= access_level_e'(pwdata_i[2:0]);
        login_cnt_q <= LOGIN_LIMIT[32:0];
      end else begin
        // R12 invalid pin logs off
        remote_q    <= LVL_NONE;
        login_cnt_q <= 33'h0;
      end
    end else if (act_req && act_ok && act_code == ACT_LOGOFF) begin
      remote_q    <= LVL_NONE;
      login_cnt_q <= 33'h0;
    end else if ((param_req && param_ok) || (act_req && act_ok)) begin
      // R11 each accepted parameter write or action other than logoff restarts the timeout
      login_cnt_q <= LOGIN_LIMIT[32:0];
    end else if (login_expire) begin
      // R11 session ends on timeout
      remote_q <= LVL_NONE;
    end else if (login_cnt_q != 33'h0) begin
      login_cnt_q <= login_cnt_q - 33'h1;
    end
  end

  // R07 refused secured write raises mismatch; set wins over clear
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mismatch_q <= 1'b0;
    end else if (param_req && !param_ok && secured) begin
      mismatch_q <= 1'b1;
    end else if (wr_en && paddr_i == ADDR_CONTROL &&
                 pwdata_i[CTL_MISMATCH]) begin
      mismatch_q <= 1'b1;
    end else if (wr_en && paddr_i == ADDR_CONTROL &&
                 pwdata_i[CTL_CLR_MISMATCH]) begin
      mismatch_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // meter strobes and result
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      param_write_o  <= 1'b0;
      action_pulse_o <= 8'h00;
      remote_reset_o <= 1'b0;
      result_q       <= 32'h0;
    end else begin
      param_write_o  <= param_req & param_ok;
      action_pulse_o <= (act_req && act_ok) ? act_code : 8'h00;
      // R23 full reset strobe
      remote_reset_o <= act_req & act_ok & (act_code == ACT_RESET);
      if (param_req) begin
        result_q <= {31'h0, param_ok};
      end else if (act_req) begin
        result_q <= {31'h0, act_ok};
      end
    end
  end

  // ---------------------------------------------------------------
  // loop current
  // ---------------------------------------------------------------
  // setpoint kept apart so the loop returns to it once an alarm clears
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      setpoint_q <= LOOP_FIXED_UA;
    end else if (wr_en && paddr_i == ADDR_LOOP) begin
      setpoint_q <= pwdata_i[15:0];
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      loop_current_o <= LOOP_FIXED_UA;
    end else if (fixed_mode) begin
      // R16 fixed at 4 mA
      // R20 alarm ignored in multi-drop
      loop_current_o <= LOOP_FIXED_UA;
    end else if (|summary[SUM_MALFUNCTION]) begin
      loop_current_o <= ctl_q[CTL_ALARM_HIGH] ? LOOP_ALARM_HI
                                              : LOOP_ALARM_LO;
    end else begin
      loop_current_o <= setpoint_q;
    end
  end

  // ---------------------------------------------------------------
  // apb read path, one wait-free access
  // ---------------------------------------------------------------
  logic [31:0] rd_mux;
  logic        rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    unique case (paddr_i)
      ADDR_METER_FLAGS:   rd_mux = {16'h0, flags_q};
      // R01 eight-byte reply over two words
      ADDR_ADD_STATUS_LO: rd_mux = add_status[31:0];
      ADDR_ADD_STATUS_HI: rd_mux = add_status[63:32];
      ADDR_SUMMARY:       rd_mux = {24'h0, summary};
      ADDR_SECURITY:      rd_mux = {16'h0, sec_word};
      ADDR_CONTROL:       rd_mux = {22'h0, mismatch_q, ctl_q[8:0]};
      ADDR_POLL:          rd_mux = {24'h0, poll_q};
      ADDR_RESULT:        rd_mux = result_q;
      ADDR_LOOP:          rd_mux = {16'h0, loop_current_o};
      ADDR_WRITE_REQ,
      ADDR_ACTION,
      ADDR_LOGIN:         rd_mux = 32'h0;
      default: begin
        rd_mux = APB_ERR_DATA;
        rd_hit = 1'b0;
      end
    endcase
  end

  // R08 reads never gated by security
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prdata_o  <= 32'h0;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= psel_i & ~penable_i;
      pslverr_o <= psel_i & ~penable_i & ~rd_hit;
      prdata_o  <= (psel_i & ~pwrite_i) ? rd_mux : 32'h0;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  error_sum_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    add_status[0] |-> summary[SUM_MALFUNCTION] & summary[SUM_MORE_STATUS])
    else $error("error flag missing summary"); // R03
  warn_sum_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    add_status[2] |-> summary[SUM_PV_RANGE] & summary[SUM_MORE_STATUS])
    else $error("full scale summary wrong"); // R04
  undef_zero_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    add_status[31:9] == 23'h0 && add_status[63:34] == 30'h0)
    else $error("undefined status bit set"); // R02
  fixed_loop_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    fixed_mode |=> loop_current_o == LOOP_FIXED_UA)
    else $error("loop not fixed"); // R16
  fixed_flag_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    summary[SUM_FIXED] == (poll_q != 8'h00))
    else $error("fixed flag wrong"); // R17
  menu_block_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    param_req && ctl_q[CTL_LOCAL_MENU] |=> !param_write_o)
    else $error("write during menu use"); // R10
  secure_lvl_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    param_req && secured && remote_q < pwdata_i[2:0] |=> !param_write_o)
    else $error("write below level"); // R09
  expired_mm_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    param_req && secured && remote_q == LVL_NONE && pwdata_i[2:0] != 3'h0
    |=> mismatch_q)
    else $error("mismatch not raised"); // R07
  bad_pin_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    login_req && !pwdata_i[31] |=> remote_q == LVL_NONE)
    else $error("invalid pin kept login"); // R12
  sec_onehot_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    $onehot(sec_word[12:8]) && $onehot(sec_word[5:1]))
    else $error("security level not one-hot"); // R15
  act_menu_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    act_req && ctl_q[CTL_LOCAL_MENU] |=> action_pulse_o == 8'h00)
    else $error("action during menu use"); // R10
  login_drop_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    login_expire && !wr_en |=> remote_q == LVL_NONE)
    else $error("login outlived timeout"); // R11
  reset_lvl_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    act_req && secured && remote_q < LVL_SERVICE |=> !remote_reset_o)
    else $error("reset below service level"); // R23

endmodule : field_status_security_logic

/* File: hdl/field_status_pkg.sv */
package field_status_pkg;

  // ---------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------
  localparam logic [11:0] ADDR_METER_FLAGS  = 12'h000;
  localparam logic [11:0] ADDR_ADD_STATUS_LO = 12'h004;
  localparam logic [11:0] ADDR_ADD_STATUS_HI = 12'h008;
  localparam logic [11:0] ADDR_SUMMARY       = 12'h00C;
  localparam logic [11:0] ADDR_SECURITY      = 12'h010;
  localparam logic [11:0] ADDR_CONTROL       = 12'h014;
  localparam logic [11:0] ADDR_POLL          = 12'h018;
  localparam logic [11:0] ADDR_WRITE_REQ     = 12'h01C;
  localparam logic [11:0] ADDR_ACTION        = 12'h020;
  localparam logic [11:0] ADDR_LOGIN         = 12'h024;
  localparam logic [11:0] ADDR_RESULT        = 12'h028;
  localparam logic [11:0] ADDR_LOOP          = 12'h02C;

  // ---------------------------------------------------------------
  // field positions and values
  // ---------------------------------------------------------------
  localparam int ADD_STATUS_BYTES = 8;
  localparam int SUM_PV_RANGE     = 0;
  localparam int SUM_FIXED        = 3;
  localparam int SUM_MORE_STATUS  = 4;
  localparam int SUM_MALFUNCTION  = 7;
  localparam int SEC_SECURED      = 0;
  localparam int SEC_LOCAL_BASE   = 1;
  localparam int SEC_REMOTE_BASE  = 8;
  localparam int CTL_SECURED      = 0;
  localparam int CTL_LOCAL_MENU   = 1;
  localparam int CTL_LINK_FAIL    = 2;
  localparam int CTL_ALARM_HIGH   = 3;
  localparam int CTL_LEVEL_LSB    = 4;
  localparam int CTL_MISMATCH     = 7;
  localparam int CTL_CLR_MISMATCH = 8;
  localparam logic [7:0] ACT_SAVE_TOTALS = 8'h06;
  localparam logic [7:0] ACT_CLEAR_FIRST = 8'h07;
  localparam logic [7:0] ACT_CLEAR_LAST  = 8'h0D;
  localparam logic [7:0] ACT_CLEAR_PWR   = 8'h15;
  localparam logic [7:0] ACT_RESET       = 8'h17;
  localparam logic [7:0] ACT_BATCH       = 8'h1B;
  localparam logic [7:0] ACT_LOGOFF      = 8'h1C;
  localparam logic [7:0] POLL_RESET      = 8'h00;
  // loop current codes in microamps
  localparam logic [15:0] LOOP_FIXED_UA  = 16'h0FA0;
  localparam logic [15:0] LOOP_ALARM_LO  = 16'h0E10;
  localparam logic [15:0] LOOP_ALARM_HI  = 16'h55F0;
  localparam logic [31:0] APB_ERR_DATA   = 32'h0000_0000;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam longint CLOCK_HZ      = 25_000_000;
  localparam longint LOGIN_TIME_S  = 300;
  localparam longint LOGIN_CYCLES  = LOGIN_TIME_S * CLOCK_HZ;

  typedef enum logic [2:0] {
    LVL_NONE    = 3'h0,
    LVL_USER    = 3'h1,
    LVL_SERVICE = 3'h2,
    LVL_ADMIN   = 3'h3,
    LVL_FACTORY = 3'h4
  } access_level_e;

  typedef struct packed {
    logic [7:0] byte1;
    logic [7:0] byte0;
  } meter_flags_s;

endpackage : field_status_pkg

/* File: verification/meter_core_model.sv */
`timescale 1ns/1ns
// ---------------------------------------------------------------
// meter core behind the block: tallies write and reset strobes, keeps last action code
// ---------------------------------------------------------------
module meter_core_model (
  // clock and reset
  input  wire logic       clock_i,
  input  wire logic       resetn_i,
  // strobes from the block
  input  wire logic       param_write_i,
  input  wire logic [7:0] action_i,
  input  wire logic       remote_reset_i,
  // tallies and last action code
  output logic      [7:0] writes_o,
  output logic      [7:0] action_o,
  output logic      [7:0] resets_o
);
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) writes_o <= 8'h00;
    else if (param_write_i) writes_o <= writes_o + 8'h01;
  end
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) action_o <= 8'h00;
    else if (action_i != 8'h00) action_o <= action_i;
  end
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) resets_o <= 8'h00;
    else if (remote_reset_i) resets_o <= resets_o + 8'h01;
  end
endmodule : meter_core_model

/* File: verification/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  import field_status_pkg::*;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  localparam logic [31:0] W16 = 32'h0000_FFFF;
  localparam logic [31:0] B8  = 32'h0000_00FF;
  logic        clock_i, resetn_i, psel_i, penable_i, pwrite_i;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rdata;
  logic        pready_o, pslverr_o, param_write_o, remote_reset_o, rerr;
  logic [15:0] loop_current_o;
  logic [7:0]  action_pulse_o, writes, last_act, resets;
  logic [7:0]  codes [9];
  logic        err;
  int          fails, compares, cycles, i;

  field_status_security_logic #(.LOGIN_LIMIT(200)) i_dut (
    .clock_i(clock_i), .resetn_i(resetn_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .loop_current_o(loop_current_o),
    .param_write_o(param_write_o), .action_pulse_o(action_pulse_o),
    .remote_reset_o(remote_reset_o));

  meter_core_model i_core (
    .clock_i(clock_i), .resetn_i(resetn_i),
    .param_write_i(param_write_o), .action_i(action_pulse_o),
    .remote_reset_i(remote_reset_o), .writes_o(writes),
    .action_o(last_act), .resets_o(resets));

  // ---------------------------------------------------------------
  // checking and bus tasks
  // ---------------------------------------------------------------
  task automatic check(input string n, input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      fails++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask : check

  task end_of_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clock_i);
    psel_i   <= 1'b1;
    pwrite_i <= w;
    paddr_i  <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    do @(posedge clock_i); while (pready_o !== 1'b1);
    rdata = prdata_o;
    rerr  = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rc(input string n, input logic [11:0] a,
                    input logic [31:0] m, e);
    apb(1'b0, a, 32'h0000_0000);
    check(n, rdata & m, e);
  endtask : rc

  task automatic res(input logic [31:0] e);
    rc("result", ADDR_RESULT, 32'h0000_0001, e);
  endtask : res

  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  // hang guard, well above the under one thousand cycles needed
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      end_of_test();
    end
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    resetn_i = 1'b0; psel_i = 1'b0; penable_i = 1'b0; pwrite_i = 1'b0;
    paddr_i = 12'h000; pwdata_i = 32'h0000_0000;
    codes = '{ACT_CLEAR_FIRST, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C,
              ACT_CLEAR_LAST, ACT_CLEAR_PWR, ACT_BATCH};
    repeat (2) @(posedge clock_i);
    resetn_i <= 1'b1;
    rc("poll", ADDR_POLL, B8, 32'h0000_0000);
    wr(ADDR_LOOP, 32'h0000_2EE0);
    for (i = 0; i < 9; i++) begin
      err = (i inside {0, 1, 3, 7, 8});
      wr(ADDR_METER_FLAGS, 32'h0000_0001 << i);
      rc("lo", ADDR_ADD_STATUS_LO, ALL, 32'h0000_0001 << i);
      rc("sum", ADDR_SUMMARY, B8, err ? 32'h0000_0090 :
         (i == 2 ? 32'h0000_0011 : 32'h0000_0010));
      check("loop", 32'(loop_current_o),
            err ? 32'(LOOP_ALARM_LO) : 32'h0000_2EE0);
    end
    wr(ADDR_METER_FLAGS, ALL);
    rc("lo", ADDR_ADD_STATUS_LO, ALL, 32'h0000_01FF);
    rc("hi", ADDR_ADD_STATUS_HI, ALL, 32'h0000_0000);
    rc("sum", ADDR_SUMMARY, B8, 32'h0000_0091);
    wr(ADDR_CONTROL, 32'h0000_0008);
    wr(ADDR_POLL, 32'h0000_0005);
    rc("sum", ADDR_SUMMARY, B8, 32'h0000_0099);
    check("loop", 32'(loop_current_o), 32'(LOOP_FIXED_UA));
    wr(ADDR_POLL, 32'h0000_0000);
    rc("poll", ADDR_POLL, B8, 32'h0000_0000);
    check("loop", 32'(loop_current_o), 32'(LOOP_ALARM_HI));
    wr(ADDR_METER_FLAGS, 32'h0000_0000);
    wr(ADDR_CONTROL, 32'h0000_0004);
    rc("hi", ADDR_ADD_STATUS_HI, ALL, 32'h0000_0001);
    rc("sum", ADDR_SUMMARY, B8, 32'h0000_0090);
    wr(ADDR_CONTROL, 32'h0000_0080);
    rc("hi", ADDR_ADD_STATUS_HI, ALL, 32'h0000_0002);
    rc("sum", ADDR_SUMMARY, B8, 32'h0000_0010);
    wr(ADDR_CONTROL, 32'h0000_0100);
    rc("hi", ADDR_ADD_STATUS_HI, ALL, 32'h0000_0000);
    // -------------------------------------------------------------
    // security
    // -------------------------------------------------------------
    for (i = 0; i < 5; i++) begin
      wr(ADDR_CONTROL, 32'h0000_0001 | (i << 4));
      rc("sec", ADDR_SECURITY, W16,
         32'h0000_0101 | (32'h0000_0002 << i));
    end
    wr(ADDR_CONTROL, 32'h0000_0021);
    wr(ADDR_WRITE_REQ, 32'h0000_0001);
    res(32'h0000_0000);
    check("err", 32'(rerr), 32'h0000_0000);
    rc("hi", ADDR_ADD_STATUS_HI, ALL, 32'h0000_0002);
    check("writes", 32'(writes), 32'h0000_0000);
    wr(ADDR_CONTROL, 32'h0000_0121);
    for (i = 0; i < 5; i++) begin
      wr(ADDR_LOGIN, 32'h8000_0000 | i);
      rc("sec", ADDR_SECURITY, W16,
         32'h0000_0009 | (32'h0000_0100 << i));
    end
    wr(ADDR_LOGIN, 32'h8000_0002);
    wr(ADDR_WRITE_REQ, 32'h0000_0002);
    res(32'h0000_0001);
    check("writes", 32'(writes), 32'h0000_0001);
    wr(ADDR_WRITE_REQ, 32'h0000_0003);
    res(32'h0000_0000);
    wr(ADDR_CONTROL, 32'h0000_0121);
    foreach (codes[k]) begin
      wr(ADDR_ACTION, 32'(codes[k]));
      res(32'h0000_0001);
      check("act", 32'(last_act), 32'(codes[k]));
    end
    wr(ADDR_CONTROL, 32'h0000_0023);
    wr(ADDR_WRITE_REQ, 32'h0000_0001);
    res(32'h0000_0000);
    wr(ADDR_CONTROL, 32'h0000_0121);
    wr(ADDR_WRITE_REQ, 32'h0000_0002);
    res(32'h0000_0001);
    repeat (150) @(posedge clock_i);
    wr(ADDR_WRITE_REQ, 32'h0000_0002);
    res(32'h0000_0001);
    repeat (150) @(posedge clock_i);
    rc("sec", ADDR_SECURITY, W16, 32'h0000_0409);
    repeat (60) @(posedge clock_i);
    rc("sec", ADDR_SECURITY, W16, 32'h0000_0109);
    wr(ADDR_WRITE_REQ, 32'h0000_0001);
    res(32'h0000_0000);
    rc("hi", ADDR_ADD_STATUS_HI, ALL, 32'h0000_0002);
    wr(ADDR_CONTROL, 32'h0000_0121);
    wr(ADDR_LOGIN, 32'h8000_0002);
    wr(ADDR_LOGIN, 32'h0000_0002);
    rc("sec", ADDR_SECURITY, W16, 32'h0000_0109);
    wr(ADDR_ACTION, 32'(ACT_CLEAR_FIRST));
    res(32'h0000_0000);
    wr(ADDR_ACTION, 32'(ACT_SAVE_TOTALS));
    res(32'h0000_0001);
    check("act", 32'(last_act), 32'(ACT_SAVE_TOTALS));
    wr(ADDR_LOGIN, 32'h8000_0002);
    wr(ADDR_ACTION, 32'(ACT_LOGOFF));
    res(32'h0000_0001);
    rc("sec", ADDR_SECURITY, W16, 32'h0000_0109);
    wr(ADDR_POLL, 32'h0000_0003);
    rc("poll", ADDR_POLL, B8, 32'h0000_0003);
    wr(ADDR_POLL, 32'h0000_0000);
    apb(1'b0, 12'h030, 32'h0000_0000);
    check("slverr", 32'(rerr), 32'h0000_0001);
    check("rdata", rdata, APB_ERR_DATA);
    wr(ADDR_ACTION, 32'(ACT_RESET));
    res(32'h0000_0000);
    check("resets", 32'(resets), 32'h0000_0000);
    wr(ADDR_CONTROL, 32'h0000_0000);
    wr(ADDR_WRITE_REQ, 32'h0000_0004);
    res(32'h0000_0001);
    wr(ADDR_CONTROL, 32'h0000_0001);
    wr(ADDR_LOGIN, 32'h8000_0002);
    wr(ADDR_ACTION, 32'(ACT_RESET));
    rc("poll", ADDR_POLL, B8, 32'h0000_0000);
    check("resets", 32'(resets), 32'h0000_0001);
    end_of_test();
  end
endmodule : tb_top
